// File: eccwc_checker.sv
module eccwc_checker #(
  parameter int ADDR_W = 32,
  parameter int ID_W = 4,
  parameter int MAXLEN_W = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  // Configuration
  input wire logic bus32,
  input wire logic eccEnable,
  input wire logic [ADDR_W-1:0] eccBase,
  input wire logic [ADDR_W-1:0] eccLimit,
  // Transaction command from initiators
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [MAXLEN_W-1:0] cmdBytes,
  input wire logic [ID_W-1:0] cmdId,
  // Response to initiators
  output logic rspValid,
  output logic [1:0] rspStatus,
  output logic [ID_W-1:0] rspId,
  // Error interrupt and log
  output logic errIrq,
  input wire logic errIrqClear,
  output logic logValid,
  output logic logWrite,
  output logic [ID_W-1:0] logId,
  output logic [ADDR_W-1:0] logAddr
);

  // ==========================================================================
  // Quantum size from the bus width
  logic [2:0] qBytes;
  logic [2:0] qMask;

  always_comb
  begin
    qBytes = 3'(eccwc_pkg::BUS16_BYTES);
    if (bus32)
    begin
      qBytes = 3'(eccwc_pkg::BUS32_BYTES);
    end
    // Low bits that must be zero in a whole number of quanta
    qMask = qBytes - 3'h1;
  end

  // ==========================================================================
  // Command acceptance
  logic taken;
  logic takenWrite;

  always_comb
  begin
    // A command counts only on an enabled edge
    taken = cmdValid && clkEn;
    takenWrite = taken && cmdWrite;
  end

  // ==========================================================================
  // Region, size and alignment checks
  logic inEcc;
  logic aboveBase;
  logic belowLimit;
  logic sizeOk;
  logic alignOk;
  logic isWrite;
  logic illegal;

  always_comb
  begin
    // Only the start address decides the region
    aboveBase = cmdAddr >= eccBase;
    belowLimit = cmdAddr <= eccLimit;
    inEcc = eccEnable && aboveBase && belowLimit;
    // A zero length counts as smaller than one quantum
    sizeOk = (cmdBytes != '0) && ((cmdBytes & MAXLEN_W'(qMask)) == '0);
    alignOk = (cmdAddr & ADDR_W'(qMask)) == '0;
    isWrite = takenWrite;
    illegal = isWrite && inEcc && !(sizeOk && alignOk);
  end

  // ==========================================================================
  // Response to the initiator
  logic rspValid_q;
  logic rspValid_d;
  logic [1:0] rspStatus_q;
  logic [1:0] rspStatus_d;
  logic [ID_W-1:0] rspId_q;
  logic [ID_W-1:0] rspId_d;

  always_comb
  begin
    rspValid_d = taken;
    rspId_d = '0;
    rspStatus_d = eccwc_pkg::RESP_NONE;
    if (taken)
    begin
      rspId_d = cmdId;
    end
    if (illegal)
    begin
      rspStatus_d = eccwc_pkg::RESP_ERR;
    end
    else if (taken)
    begin
      // Legal traffic is never answered with an error
      rspStatus_d = eccwc_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rspValid_q <= 1'h0;
      rspStatus_q <= eccwc_pkg::RESP_NONE;
      rspId_q <= '0;
    end
    else if (clkEn)
    begin
      rspValid_q <= rspValid_d;
      rspStatus_q <= rspStatus_d;
      rspId_q <= rspId_d;
    end
  end

  // ==========================================================================
  // Error interrupt
  logic errIrq_q;
  logic errIrq_d;
  logic irqSet;
  logic irqHold;

  always_comb
  begin
    // Only an illegal write may set the interrupt
    irqSet = illegal;
    irqHold = errIrq_q && !errIrqClear;
    // Set wins over a simultaneous clear
    errIrq_d = irqSet || irqHold;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      errIrq_q <= 1'h0;
    end
    else if (clkEn)
    begin
      errIrq_q <= errIrq_d;
    end
  end

  // ==========================================================================
  // Log of the last illegal write
  logic logValid_q;
  logic logValid_d;
  logic logWrite_q;
  logic logWrite_d;
  logic [ID_W-1:0] logId_q;
  logic [ID_W-1:0] logId_d;
  logic [ADDR_W-1:0] logAddr_q;
  logic [ADDR_W-1:0] logAddr_d;

  always_comb
  begin
    logValid_d = logValid_q;
    logWrite_d = logWrite_q;
    logId_d = logId_q;
    logAddr_d = logAddr_q;
    // Each new illegal write replaces the previous entry
    if (illegal)
    begin
      logValid_d = 1'h1;
      logWrite_d = cmdWrite;
      logId_d = cmdId;
      logAddr_d = cmdAddr;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      logValid_q <= eccwc_pkg::LOG_RESET;
      logWrite_q <= eccwc_pkg::LOG_RESET;
      logId_q <= '0;
      logAddr_q <= '0;
    end
    else if (clkEn)
    begin
      logValid_q <= logValid_d;
      logWrite_q <= logWrite_d;
      logId_q <= logId_d;
      logAddr_q <= logAddr_d;
    end
  end

  // ==========================================================================
  // Outputs, each straight from its register
  assign rspValid = rspValid_q;
  assign rspStatus = rspStatus_q;
  assign rspId = rspId_q;
  assign errIrq = errIrq_q;
  assign logValid = logValid_q;
  assign logWrite = logWrite_q;
  assign logId = logId_q;
  assign logAddr = logAddr_q;

endmodule

// File: eccwc_pkg.sv
package eccwc_pkg;

  // Bus width selection: quantum is one data-bus word
  localparam int BUS16_BYTES = 2;
  localparam int BUS32_BYTES = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [1:0] RESP_NONE = 2'h0;
  localparam logic LOG_RESET = 1'h0;

  typedef enum logic [1:0]
  {
    ACC_WRITE = 2'h1,
    ACC_READ = 2'h0
  } eccwc_acc_type;

endpackage

// File: eccwc_initiator.sv
module eccwc_initiator(
  input wire logic mclk,
  output logic cV,
  output logic cW,
  output logic [31:0] cA,
  output logic [7:0] cB,
  output logic [3:0] cI
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cV = 1'h0;
    cW = 1'h0;
    cA = 32'h0;
    cB = 8'h0;
    cI = 4'h0;
  end
  // One command per call, held for exactly one rising clock edge
  task issue(input logic w, input logic [31:0] a, input logic [7:0] b, input logic [3:0] i);
    @(posedge mclk);
    cV <= 1'h1;
    cW <= w;
    cA <= a;
    cB <= b;
    cI <= i;
    @(posedge mclk);
    cV <= 1'h0;
    cA <= ~a;
    #1;
  endtask
endmodule

// File: eccwc_checker_asserts.sv
module eccwc_checker_asserts(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic rspValid,
  input wire logic [1:0] rspStatus,
  input wire logic errIrq,
  input wire logic errIrqClear,
  input wire logic logValid,
  input wire logic logWrite
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  rsp_follows_a: assert property (clkEn && cmdValid |=> rspValid) else $error("no response");
  read_ok_a: assert property (clkEn && cmdValid && !cmdWrite |=> rspStatus == 2'h0) else $error("read err");
  err_irq_a: assert property (rspStatus == 2'h2 |-> errIrq) else $error("irq missing");
  irq_cause_a: assert property ($rose(errIrq) |-> rspStatus == 2'h2) else $error("false irq");
  irq_clear_a: assert property (clkEn && errIrqClear && !(cmdValid && cmdWrite) |=> !errIrq) else $error("irq stuck");
  log_on_err_a: assert property (rspStatus == 2'h2 |-> logValid && logWrite) else $error("log missing");
  idle_status_a: assert property (!rspValid |-> rspStatus == 2'h0) else $error("idle status");
  freeze_irq_a: assert property (!clkEn |=> $stable(errIrq)) else $error("irq moved");
endmodule
bind eccwc_checker eccwc_checker_asserts eccwc_checker_asserts_i(.*);

// File: eccwc_checker_test.sv
module eccwc_checker_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rstn = 0, b32 = 1, clr = 0, ce = 1, rV, lV, lW, irq, cV, cW;
  logic [31:0] cA;
  logic [7:0] cB;
  logic [3:0] cI;
  logic [1:0] rS;
  logic [3:0] rI, lI;
  logic [31:0] lA;
  int num_errors = 0, n_checks = 0;
  eccwc_initiator eccwc_initiator_i(.mclk(mclk), .cV(cV), .cW(cW), .cA(cA), .cB(cB), .cI(cI));
  eccwc_checker eccwc_checker_i(.mclk(mclk), .rstn(rstn), .clkEn(ce), .bus32(b32), .eccEnable(1'h1),
    .eccBase(32'h100), .eccLimit(32'h1FF), .cmdValid(cV), .cmdWrite(cW),
    .cmdAddr(cA), .cmdBytes(cB), .cmdId(cI),
    .rspValid(rV), .rspStatus(rS), .rspId(rI), .errIrq(irq), .errIrqClear(clr), .logValid(lV),
    .logWrite(lW), .logId(lI), .logAddr(lA));
  initial forever #20 mclk = ~mclk;
  task chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cmd(input logic w, bs, input logic [31:0] a, input logic [7:0] b, input logic [3:0] i, input logic e, q);
    @(posedge mclk) b32 <= bs;
    eccwc_initiator_i.issue(w, a, b, i);
    chk({rV, rS, rI}, {1'h1, e ? 2'h2 : 2'h0, i});
    chk(irq, q);
    if (e)
    begin
      chk({lV, lW, lI}, {2'h3, i});
      chk(lA, a);
    end
  endtask
  task t_legal;
    cmd(1, 1, 32'h104, 4, 1, 0, 0);
    cmd(0, 1, 32'h101, 1, 2, 0, 0);
    cmd(1, 1, 32'h300, 1, 4, 0, 0);
    $display("legal done");
  endtask
  task t_illegal;
    cmd(1, 1, 32'h101, 2, 3, 1, 1);
    cmd(1, 0, 32'h102, 2, 5, 0, 1);
    cmd(1, 1, 32'h104, 0, 6, 1, 1);
    @(posedge mclk) clr <= 1;
    @(posedge mclk) clr <= 0;
    #1 chk(irq, 0);
    $display("illegal done");
  endtask
  task t_freeze;
    @(posedge mclk) ce <= 0;
    eccwc_initiator_i.issue(1, 32'h101, 2, 7);
    chk({rV, rS, rI}, 0);
    chk({irq, lI}, {1'h0, 4'h6});
    @(posedge mclk) ce <= 1;
    $display("freeze done");
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1;
    t_legal;
    t_illegal;
    t_freeze;
    complete_run;
  end
endmodule
